// File: design/csf_core.sv
// status flag generation, flag registers and address forming
`timescale 1ns/1ps
`include "csf_consts.svh"
//
// Operation
// RL1 - primary and alternate six-bit flag registers
// RL2 - only C, PV, Z, S are testable
// RL3 - full eight codes; relative set four
// RL4 - carry on add carry or sub borrow
// RL5 - carry links rotate-through-carry ends
// RL6 - left rotates/shifts: carry gets bit 7
// RL7 - right rotates/shifts: carry gets bit 0
// RL8 - and, or, xor clear carry
// RL9 - set-carry forces one; invert complements
// RL10 - decimal adjust sets carry on correction
// RL11 - add clears N, subtract sets N
// RL12 - arithmetic PV flags signed overflow
// RL13 - overflow when sign carries differ
// RL14 - add overflow needs like-sign operands
// RL15 - sub overflow needs unlike-sign operands
// RL16 - logic and rotate PV is parity even
// RL17 - block ops PV clear at count zero
// RL18 - load from vector/refresh: PV gets latch
// RL19 - port input PV holds byte parity
// RL20 - half carry on bit 3/4 carry, borrow
// RL21 - index address adds sign-extended displacement
// RL22 - accumulator high, flags low in pair
// RL23 - zero flag set on zero result
// RL24 - bit test zero gets inverted bit
// RL25 - sign flag takes result msb
// RL26 - S7 Z6 H4 PV2 N1 C0 layout
module csf_core (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // operation request
   input wire logic op_vld,
   input wire csf_pkg::csf_op_e op,
   input wire logic [7:0] opnd_a,
   input wire logic [7:0] opnd_b,
   input wire logic [2:0] bit_sel,
   input wire logic [15:0] byte_count_dec,
   input wire logic second_interrupt_enable_latch,
   // condition test
   input wire logic [2:0] cc,
   input wire logic cc_short,
   output logic cc_taken,
   // index addressing
   input wire logic [15:0] index_reg,
   input wire logic [7:0] displacement,
   output logic [15:0] index_addr,
   // results
   output logic [7:0] result,
   output logic result_vld,
   output logic [7:0] flags,
   output logic [7:0] flags_alt,
   output logic [15:0] acc_flag_pair
);
   import csf_pkg::*;

   csf_state_s st_r;
   csf_state_s st_nxt;
   csf_cc_if cc_if ();

   function automatic logic par_even(input logic [7:0] v);
      par_even = ~^v;
   endfunction

   function automatic logic [7:0] pack_flags(input logic s, input logic z, input logic h,
                                             input logic pv, input logic n, input logic c);
      logic [7:0] f;
      f = `CSF_FLAG_RST;
      f[`CSF_BIT_S] = s;
      f[`CSF_BIT_Z] = z;
      f[`CSF_BIT_H] = h;
      f[`CSF_BIT_PV] = pv;
      f[`CSF_BIT_N] = n;
      f[`CSF_BIT_C] = c;
      pack_flags = f; // RL26 RL1
   endfunction

   logic [8:0] sum9;
   logic [4:0] sum_lo;
   logic [7:0] b_eff;
   logic cin;
   logic is_sub;
   logic c6_in;
   logic [7:0] daa_adj;
   logic daa_c;
   logic daa_h;
   logic [7:0] res;
   logic fc;
   logic fh;
   logic fpv;
   logic fn;
   logic fz;
   logic fs;
   logic [7:0] fold;

   always_comb begin
      fold = st_r.flags;
      is_sub = (op == CSF_OP_SUB) || (op == CSF_OP_SBC) || (op == CSF_OP_CMP);
      cin = ((op == CSF_OP_ADC) || (op == CSF_OP_SBC)) ? fold[`CSF_BIT_C] : 1'b0;
      // subtract as a + ~b + ~cin; borrow is inverted carry
      b_eff = is_sub ? ~opnd_b : opnd_b;
      sum9 = {1'b0, opnd_a} + {1'b0, b_eff} + {8'h00, (is_sub ? ~cin : cin)};
      sum_lo = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, (is_sub ? ~cin : cin)};
      c6_in = opnd_a[7] ^ b_eff[7] ^ sum9[7];
      // decimal correction
      daa_c = fold[`CSF_BIT_C] || (opnd_a > `CSF_DAA_HI_LIM);
      daa_h = fold[`CSF_BIT_H] || (opnd_a[3:0] > `CSF_DAA_LO_LIM);
      daa_adj = (daa_c ? `CSF_DAA_HI_ADJ : 8'h00) | (daa_h ? `CSF_DAA_LO_ADJ : 8'h00);
      res = opnd_a;
      fc = fold[`CSF_BIT_C];
      fh = fold[`CSF_BIT_H];
      fpv = fold[`CSF_BIT_PV];
      fn = fold[`CSF_BIT_N];
      fz = fold[`CSF_BIT_Z];
      fs = fold[`CSF_BIT_S];
      case (op)
         CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC, CSF_OP_CMP: begin
            res = sum9[7:0];
            fc = is_sub ? ~sum9[8] : sum9[8]; // RL4
            fh = is_sub ? ~sum_lo[4] : sum_lo[4]; // RL20
            fpv = c6_in ^ sum9[8]; // RL12 RL13 RL14 RL15
            fn = is_sub; // RL11
         end
         CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR: begin
            res = (op == CSF_OP_AND) ? (opnd_a & opnd_b) :
                  (op == CSF_OP_OR) ? (opnd_a | opnd_b) : (opnd_a ^ opnd_b);
            fc = 1'b0; // RL8
            fh = (op == CSF_OP_AND);
            fn = 1'b0;
            fpv = par_even(res); // RL16
         end
         CSF_OP_RLC, CSF_OP_SLA: begin
            res = (op == CSF_OP_RLC) ? {opnd_a[6:0], opnd_a[7]} : {opnd_a[6:0], 1'b0};
            fc = opnd_a[7]; // RL6
            fh = 1'b0;
            fn = 1'b0;
            fpv = par_even(res); // RL16
         end
         CSF_OP_RRC, CSF_OP_SRA, CSF_OP_SRL: begin
            res = (op == CSF_OP_RRC) ? {opnd_a[0], opnd_a[7:1]} :
                  (op == CSF_OP_SRA) ? {opnd_a[7], opnd_a[7:1]} : {1'b0, opnd_a[7:1]};
            fc = opnd_a[0]; // RL7
            fh = 1'b0;
            fn = 1'b0;
            fpv = par_even(res); // RL16
         end
         CSF_OP_RL, CSF_OP_RR: begin
            res = (op == CSF_OP_RL) ? {opnd_a[6:0], fold[`CSF_BIT_C]} : {fold[`CSF_BIT_C], opnd_a[7:1]}; // RL5
            fc = (op == CSF_OP_RL) ? opnd_a[7] : opnd_a[0]; // RL5
            fh = 1'b0;
            fn = 1'b0;
            fpv = par_even(res); // RL16
         end
         CSF_OP_SCF: begin
            fc = 1'b1; // RL9
            fh = 1'b0;
            fn = 1'b0;
         end
         CSF_OP_CCF: begin
            fc = ~fold[`CSF_BIT_C]; // RL9
            fn = 1'b0;
         end
         CSF_OP_DAA: begin
            res = fold[`CSF_BIT_N] ? (opnd_a - daa_adj) : (opnd_a + daa_adj);
            fc = daa_c; // RL10
            fh = 1'b0;
            fpv = par_even(res);
         end
         CSF_OP_BIT: begin
            fz = ~opnd_a[bit_sel]; // RL24
            fh = 1'b1;
            fn = 1'b0;
         end
         CSF_OP_BLK: begin
            fpv = (byte_count_dec != 16'h0000); // RL17
         end
         CSF_OP_LDIR_A: begin
            fpv = second_interrupt_enable_latch; // RL18
            fh = 1'b0;
            fn = 1'b0;
         end
         CSF_OP_IN: begin
            fpv = par_even(opnd_a); // RL19
            fh = 1'b0;
            fn = 1'b0;
         end
         default: begin
            res = opnd_a;
         end
      endcase
      case (op)
         CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC, CSF_OP_CMP,
         CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_RLC, CSF_OP_RRC, CSF_OP_RL, CSF_OP_RR,
         CSF_OP_SLA, CSF_OP_SRA, CSF_OP_SRL, CSF_OP_DAA, CSF_OP_LDIR_A, CSF_OP_IN: begin
            fz = (res == 8'h00); // RL23
            fs = res[7]; // RL25
         end
         default: begin
            fz = fz;
         end
      endcase
      st_nxt = st_r;
      st_nxt.result_vld = 1'b0;
      if (op_vld) begin
         st_nxt.result_vld = 1'b1;
         st_nxt.result = res;
         case (op)
            CSF_OP_EXAF: begin
               st_nxt.flags = st_r.flags_alt; // RL1
               st_nxt.flags_alt = st_r.flags;
            end
            CSF_OP_LDF: begin
               st_nxt.flags = opnd_b & `CSF_FLAG_MASK; // RL1
            end
            CSF_OP_NOP: begin
               st_nxt.result_vld = 1'b0;
            end
            default: begin
               st_nxt.flags = pack_flags(fs, fz, fh, fpv, fn, fc);
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign result = st_r.result;
   assign result_vld = st_r.result_vld;
   assign flags = st_r.flags;
   assign flags_alt = st_r.flags_alt;
   assign acc_flag_pair = {st_r.result, st_r.flags}; // RL22
   assign index_addr = index_reg + {{8{displacement[7]}}, displacement}; // RL21

   assign cc_if.flags = st_r.flags;
   assign cc_if.cc = cc;
   assign cc_if.short_set = cc_short;
   assign cc_taken = cc_if.taken; // RL2

   csf_cond u_cond (
      .cc_if(cc_if.eval)
   );
endmodule // csf_core

// File: design/csf_consts.svh
// constants for the status flag datapath
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH
`define CSF_BIT_S 7
`define CSF_BIT_Z 6
`define CSF_BIT_U5 5
`define CSF_BIT_H 4
`define CSF_BIT_U3 3
`define CSF_BIT_PV 2
`define CSF_BIT_N 1
`define CSF_BIT_C 0
`define CSF_FLAG_MASK 8'hd7
`define CSF_FLAG_RST 8'h00
`define CSF_DAA_LO_LIM 4'h9
`define CSF_DAA_HI_LIM 8'h99
`define CSF_DAA_LO_ADJ 8'h06
`define CSF_DAA_HI_ADJ 8'h60
`endif

// File: design/csf_pkg.sv
// types for the status flag datapath
package csf_pkg;
   typedef enum logic [4:0] {
      CSF_OP_NOP, CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC, CSF_OP_CMP,
      CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR,
      CSF_OP_RLC, CSF_OP_RRC, CSF_OP_RL, CSF_OP_RR, CSF_OP_SLA, CSF_OP_SRA, CSF_OP_SRL,
      CSF_OP_SCF, CSF_OP_CCF, CSF_OP_DAA, CSF_OP_BIT, CSF_OP_BLK, CSF_OP_LDIR_A, CSF_OP_IN,
      CSF_OP_EXAF, CSF_OP_LDF
   } csf_op_e;
   typedef enum logic [2:0] {
      CSF_CC_NZ, CSF_CC_Z, CSF_CC_NC, CSF_CC_C, CSF_CC_PO, CSF_CC_PE, CSF_CC_P, CSF_CC_M
   } csf_cc_e;
   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] flags_alt;
      logic [7:0] result;
      logic result_vld;
   } csf_state_s;
endpackage

// File: design/csf_if.sv
// interface between flag core and condition evaluator
`timescale 1ns/1ps
interface csf_cc_if;
   logic [7:0] flags;
   logic [2:0] cc;
   logic short_set;
   logic taken;
   modport core (output flags, output cc, output short_set, input taken);
   modport eval (input flags, input cc, input short_set, output taken);
endinterface

// File: design/csf_cond.sv
// condition code evaluator
`timescale 1ns/1ps
`include "csf_consts.svh"
module csf_cond (
   // condition link
   csf_cc_if.eval cc_if
);
   import csf_pkg::*;
   function automatic logic cc_test(input logic [2:0] cc, input logic [7:0] f);
      case (csf_cc_e'(cc))
         CSF_CC_NZ: cc_test = ~f[`CSF_BIT_Z];
         CSF_CC_Z: cc_test = f[`CSF_BIT_Z];
         CSF_CC_NC: cc_test = ~f[`CSF_BIT_C];
         CSF_CC_C: cc_test = f[`CSF_BIT_C];
         CSF_CC_PO: cc_test = ~f[`CSF_BIT_PV];
         CSF_CC_PE: cc_test = f[`CSF_BIT_PV];
         CSF_CC_P: cc_test = ~f[`CSF_BIT_S];
         default: cc_test = f[`CSF_BIT_S];
      endcase
   endfunction
   always_comb begin
      // only c, pv, z, s are tested; short set only first four
      if (cc_if.short_set && cc_if.cc[2]) begin // RL3
         cc_if.taken = 1'b0;
      end else begin
         cc_if.taken = cc_test(cc_if.cc, cc_if.flags); // RL2 RL3
      end
   end
endmodule // csf_cond

// File: verification/csf_checker.sv
// assertions for the status flag core
`timescale 1ns/1ps
module csf_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // operation inputs
   input wire logic op_vld,
   input wire csf_pkg::csf_op_e op,
   input wire logic [15:0] byte_count_dec,
   input wire logic [2:0] cc,
   input wire logic cc_short,
   input wire logic [15:0] index_reg,
   input wire logic [7:0] displacement,
   // outputs
   input wire logic cc_taken,
   input wire logic [15:0] index_addr,
   input wire logic [7:0] result,
   input wire logic result_vld,
   input wire logic [7:0] flags,
   input wire logic [7:0] flags_alt,
   input wire logic [15:0] acc_flag_pair
);
   import csf_pkg::*;
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic lg;
   assign lg = op_vld && (op == CSF_OP_AND || op == CSF_OP_OR || op == CSF_OP_XOR);
   unused_bits_a: assert property (((flags | flags_alt) & 8'h28) == 8'h00)
      else $error("unused flag bit set");
   logic_carry_a: assert property (lg |=> !flags[0] && flags[2] == ~^result)
      else $error("logic op carry or parity wrong");
   set_carry_a: assert property (op_vld && op == CSF_OP_SCF |=> flags[0])
      else $error("set carry failed");
   invert_carry_a: assert property (op_vld && op == CSF_OP_CCF |=> flags[0] != $past(flags[0]))
      else $error("invert carry failed");
   short_set_a: assert property (cc_short && cc[2] |-> !cc_taken)
      else $error("short set took a long code");
   add_flags_a: assert property (op_vld && op == CSF_OP_ADD |=> !flags[1] && flags[7] == result[7]
      && flags[6] == (result == 8'h00))
      else $error("add flags wrong");
   sub_flag_a: assert property (op_vld && op == CSF_OP_SUB |=> flags[1])
      else $error("sub did not set n");
   block_pv_a: assert property (op_vld && op == CSF_OP_BLK |=> flags[2] == ($past(byte_count_dec) != 16'h0000))
      else $error("block pv wrong");
   index_addr_a: assert property (index_addr == index_reg + {{8{displacement[7]}}, displacement})
      else $error("index address wrong");
   pair_order_a: assert property (acc_flag_pair == {result, flags})
      else $error("pair order wrong");
   result_pulse_a: assert property (##1 result_vld == $past(op_vld && op != CSF_OP_NOP))
      else $error("result valid pulse wrong");
   cover property (op_vld && op == CSF_OP_ADD);
   cover property (op_vld && op == CSF_OP_CCF);
   cover property (cc_short && cc_taken);
endmodule // csf_checker

// File: verification/cpu_status_flag_logic_test.sv
// self-checking bench for the status flag core
`timescale 1ns/1ps
module cpu_status_flag_logic_test;
   import csf_pkg::*;
   localparam logic [11:0] PK = 12'he86;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic op_vld = 1'b0;
   csf_op_e op = CSF_OP_NOP;
   logic [7:0] opnd_a = 8'h00, opnd_b = 8'h00, displacement = 8'h00;
   logic [2:0] bit_sel = 3'h0, cc = 3'h0;
   logic [15:0] byte_count_dec = 16'h0000, index_reg = 16'h0000;
   logic second_interrupt_enable_latch = 1'b0, cc_short = 1'b0;
   logic cc_taken, result_vld;
   logic [7:0] result, flags, flags_alt;
   logic [15:0] index_addr, acc_flag_pair;
   int error_cnt = 0, n_checks = 0, cycles = 0;
   always #4 core_clk = ~core_clk;
   csf_core uut (.core_clk, .sys_rst, .op_vld, .op, .opnd_a, .opnd_b, .bit_sel, .byte_count_dec,
      .second_interrupt_enable_latch, .cc, .cc_short, .cc_taken, .index_reg, .displacement,
      .index_addr, .result, .result_vld, .flags, .flags_alt, .acc_flag_pair);
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic run(input csf_op_e o, input logic [7:0] a, b, m, ef);
      @(posedge core_clk);
      #1 op = o;
      opnd_a = a;
      opnd_b = b;
      op_vld = 1'b1;
      @(posedge core_clk);
      #1 op_vld = 1'b0;
      chk8("flags", ef, flags & m);
   endtask
   task automatic cc_all(input logic [7:0] f, input logic s);
      for (int i = 0; i < 8; i++) begin
         cc = 3'(i);
         cc_short = s;
         #0.5 chk8("cc_taken", {7'h00, f[PK[(i/2)*3 +: 3]] == i[0] && !(s && i > 3)}, {7'h00, cc_taken});
      end
   endtask
   task automatic sc_arith;
      chk8("flags", 8'h00, flags);
      run(CSF_OP_ADD, 8'h78, 8'h69, 8'hff, 8'h94);
      chk8("result", 8'he1, result);
      chk16("pair", 16'he194, acc_flag_pair);
      run(CSF_OP_ADD, 8'hff, 8'h01, 8'hff, 8'h51);
      run(CSF_OP_SUB, 8'h80, 8'h01, 8'hff, 8'h16);
      run(CSF_OP_SUB, 8'h01, 8'h02, 8'hff, 8'h93);
      run(CSF_OP_ADD, 8'h99, 8'h01, 8'h01, 8'h00);
      run(CSF_OP_DAA, 8'h9a, 8'h00, 8'h01, 8'h01);
      chk8("result", 8'h00, result);
      $display("test arith done");
   endtask
   task automatic sc_logic;
      run(CSF_OP_SCF, 8'h00, 8'h00, 8'h01, 8'h01);
      run(CSF_OP_AND, 8'hff, 8'h0f, 8'h05, 8'h04);
      run(CSF_OP_CCF, 8'h00, 8'h00, 8'h01, 8'h01);
      run(CSF_OP_OR, 8'h01, 8'h02, 8'h05, 8'h04);
      run(CSF_OP_CCF, 8'h00, 8'h00, 8'h01, 8'h01);
      run(CSF_OP_XOR, 8'h55, 8'h54, 8'h05, 8'h00);
      $display("test logic done");
   endtask
   task automatic sc_rot;
      run(CSF_OP_RL, 8'h80, 8'h00, 8'h05, 8'h05);
      run(CSF_OP_RR, 8'h00, 8'h00, 8'h05, 8'h00);
      chk8("result", 8'h80, result);
      run(CSF_OP_RLC, 8'h81, 8'h00, 8'h05, 8'h05);
      run(CSF_OP_SRL, 8'h02, 8'h00, 8'h01, 8'h00);
      run(CSF_OP_SLA, 8'h80, 8'h00, 8'h01, 8'h01);
      run(CSF_OP_RRC, 8'h00, 8'h00, 8'h01, 8'h00);
      run(CSF_OP_SRA, 8'h81, 8'h00, 8'h01, 8'h01);
      chk8("result", 8'hc0, result);
      $display("test rotate done");
   endtask
   task automatic sc_pv;
      run(CSF_OP_BLK, 8'h00, 8'h00, 8'h04, 8'h00);
      byte_count_dec = 16'h0100;
      run(CSF_OP_BLK, 8'h00, 8'h00, 8'h04, 8'h04);
      second_interrupt_enable_latch = 1'b1;
      run(CSF_OP_LDIR_A, 8'h01, 8'h00, 8'h04, 8'h04);
      second_interrupt_enable_latch = 1'b0;
      run(CSF_OP_LDIR_A, 8'h03, 8'h00, 8'h04, 8'h00);
      run(CSF_OP_IN, 8'h03, 8'h00, 8'h04, 8'h04);
      run(CSF_OP_IN, 8'h07, 8'h00, 8'h04, 8'h00);
      bit_sel = 3'h3;
      run(CSF_OP_BIT, 8'h08, 8'h00, 8'h40, 8'h00);
      bit_sel = 3'h4;
      run(CSF_OP_BIT, 8'h08, 8'h00, 8'h40, 8'h40);
      $display("test parity done");
   endtask
   task automatic sc_cc;
      run(CSF_OP_LDF, 8'h00, 8'hff, 8'hff, 8'hd7);
      run(CSF_OP_EXAF, 8'h00, 8'h00, 8'hff, 8'h00);
      chk8("flags_alt", 8'hd7, flags_alt);
      cc_all(8'h00, 1'b0);
      run(CSF_OP_EXAF, 8'h00, 8'h00, 8'hff, 8'hd7);
      cc_all(8'hd7, 1'b0);
      cc_all(8'hd7, 1'b1);
      run(CSF_OP_LDF, 8'h00, 8'h12, 8'hff, 8'h12);
      cc_all(8'h12, 1'b0);
      index_reg = 16'h1000;
      displacement = 8'hff;
      #1 chk16("index_addr", 16'h0fff, index_addr);
      displacement = 8'h7f;
      #1 chk16("index_addr", 16'h107f, index_addr);
      $display("test condition done");
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      sc_arith();
      sc_logic();
      sc_rot();
      sc_pv();
      sc_cc();
      give_verdict();
   end
endmodule // cpu_status_flag_logic_test
bind csf_core csf_checker u_chk (.core_clk, .sys_rst, .op_vld, .op, .byte_count_dec, .cc, .cc_short,
   .index_reg, .displacement, .cc_taken, .index_addr, .result, .result_vld, .flags, .flags_alt, .acc_flag_pair);
